// ==== verilog/adc_control_register.sv ====
// configuration word of a six-channel converter with its write paths
`timescale 1ns/100ps
`include "adc_cfg_defines.svh"
////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// [R01] pair enables C,B,A; reset disabled
// [R02] span bits: 0 four times, 1 twice
// [R03] internal reference on when set
// [R04] buffer bit inverted: 1 disables buffers
// [R05] host sets staggered start only with clock select
// [R06] automatic nap enabled when set
// [R07] status pin: busy or interrupt function
// [R08] status polarity swaps busy and interrupt levels
// [R09] reserved bits always read zero
// [R10] reference level 2.5 V or 3 V
// [R11] readback bit sends word on serial outputs
// [R12] serial writes upper byte unless full update
// [R13] power-down per pair; host clears enable
// [R14] clock select internal or external conversion clock
// [R15] conversion clock driven out when set
// [R16] ten-bit trim, all ones after reset
// [R17] hardware mode ignores pair, reference, clock bits
// [R18] parallel on strobe rise, serial 32nd edge
// [R19] writes only in software mode, contents kept
// [R20] any reset loads trim ones, rest zero
////////////////////////////////////////////////////////////////////////////
module adc_control_register
  import adc_cfg_pkg::*;
(
  // system
  input wire logic clk_sys,
  input wire logic rst,
  // mode and reset pins
  input wire logic reset_pin,
  input wire logic hw_sw_pin,
  input wire logic par_mode_pin,
  // parallel write port
  input wire logic wr_n,
  input wire logic cs_n,
  input wire logic [15:0] par_data,
  // serial link
  input wire logic sclk,
  input wire logic frame_n,
  input wire logic sdi,
  output wire logic sdo,
  input wire logic [31:0] result_word,
  // conversion status
  input wire logic conv_busy,
  input wire logic conv_irq,
  output logic status_pin,
  // configuration view
  output cfg_word_t config_word,
  output logic [2:0] pair_enable,
  output logic [2:0] pair_span_half,
  output logic internal_ref_on,
  output logic ref_buffer_off,
  output logic staggered_start_en,
  output logic auto_nap_en,
  output logic ref_level_3v,
  output logic [2:0] pair_powerdown,
  output logic conv_clock_source_sel,
  output logic conv_clock_output_en,
  output logic [9:0] ref_trim_value
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic cfg_word_t clean_word(input cfg_word_t w);
    clean_word = w & `CFG_RSVD_MASK;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [5:0] pin_raw;
  logic [5:0] pin_s;
  logic [15:0] data_s;
  logic rx_tgl_s;
  logic reset_s;
  logic hw_sw_s;
  logic par_mode_s;
  logic wr_n_s;
  logic cs_n_s;
  cfg_word_t rx_word;
  logic rx_tgl;

  assign pin_raw = {rx_tgl, reset_pin, hw_sw_pin, par_mode_pin, wr_n, cs_n};
  assign {rx_tgl_s, reset_s, hw_sw_s, par_mode_s, wr_n_s, cs_n_s} = pin_s;

  cfg_sync #(
    .WIDTH(6)
  ) u_pin_sync (
    .clk(clk_sys),
    .d(pin_raw),
    .q(pin_s)
  );

  // data must hold a few cycles past the strobe rise to be seen whole
  cfg_sync #(
    .WIDTH(16)
  ) u_data_sync (
    .clk(clk_sys),
    .d(par_data),
    .q(data_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // state

  cfg_word_t cfg_reg;
  cfg_word_t cfg_next;
  logic cfg_tgl_reg;
  logic ser_seen_reg;
  logic wr_q_reg;
  logic [15:0] high_hold_reg;
  logic [15:0] high_hold_next;
  logic link_rst_reg;
  par_state_t par_state_reg;
  par_state_t par_state_next;

  ////////////////////////////////////////////////////////////////////////
  // decode

  wire any_reset = rst | reset_s;
  wire sw_mode = hw_sw_s;
  wire wr_rise = wr_n_s & ~wr_q_reg & ~cs_n_s;
  wire par_take = par_mode_s & sw_mode & wr_rise; // see [R19]
  wire par_commit = par_take & (par_state_reg == PAR_HOLD);
  wire ser_evt = rx_tgl_s ^ ser_seen_reg;
  wire ser_commit = ~par_mode_s & sw_mode & ser_evt; // see [R19]
  wire [31:0] par_word = {high_hold_reg, data_s};
  wire [31:0] par_clean = clean_word(par_word);
  wire [31:0] rx_clean = clean_word(rx_word);
  // partial update keeps every bit below the upper byte
  wire [31:0] ser_merge = cfg_reg[`B_FULL_UPD] ? rx_clean :
    (rx_clean & `CFG_UPPER_MASK) | (cfg_reg & ~`CFG_UPPER_MASK); // see [R12]
  // settings that hardware mode ignores read as their defaults
  wire [31:0] eff_word = sw_mode ? cfg_reg :
    (cfg_reg & `CFG_HW_MASK); // see [R17]
  wire irq_mode = eff_word[`B_IRQ_MODE];
  wire pol = eff_word[`B_POL];
  // polarity flips both functions together
  wire status_next = irq_mode ? (conv_irq ^ ~pol) :
    (conv_busy ^ pol); // see [R07] see [R08]

  // first strobe stores the upper half, second commits the word
  always_comb begin
    par_state_next = par_state_reg;
    high_hold_next = high_hold_reg;
    case (par_state_reg)
      PAR_IDLE: begin
        if (par_take) begin
          par_state_next = PAR_HOLD;
          high_hold_next = data_s;
        end
      end
      PAR_HOLD: begin
        if (!par_mode_s || !sw_mode || par_take) begin
          par_state_next = PAR_IDLE;
        end
      end
      default: begin
        par_state_next = PAR_IDLE;
      end
    endcase
  end

  always_comb begin
    if (any_reset) begin
      cfg_next = `CFG_RESET; // see [R20] see [R16]
    end else if (par_commit) begin
      cfg_next = par_clean; // see [R18] see [R09]
    end else if (ser_commit) begin
      cfg_next = ser_merge; // see [R18] see [R09]
    end else begin
      cfg_next = cfg_reg; // see [R19]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_sys) begin
    if (any_reset) begin
      par_state_reg <= PAR_IDLE;
      high_hold_reg <= 16'h0;
      wr_q_reg <= 1'h1;
    end else begin
      par_state_reg <= par_state_next;
      high_hold_reg <= high_hold_next;
      wr_q_reg <= wr_n_s;
    end
  end

  // a change flips the toggle so the link side copies a settled word
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_reg <= `CFG_RESET;
      cfg_tgl_reg <= 1'h0;
      ser_seen_reg <= 1'h0;
      link_rst_reg <= 1'h1;
    end else begin
      cfg_reg <= cfg_next;
      if (cfg_next != cfg_reg) begin
        cfg_tgl_reg <= ~cfg_tgl_reg;
      end
      ser_seen_reg <= rx_tgl_s;
      link_rst_reg <= reset_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      config_word <= `CFG_RESET;
      pair_enable <= 3'h0;
      pair_span_half <= 3'h0;
      internal_ref_on <= 1'h0;
      ref_buffer_off <= 1'h0;
      staggered_start_en <= 1'h0;
      auto_nap_en <= 1'h0;
      ref_level_3v <= 1'h0;
      pair_powerdown <= 3'h0;
      conv_clock_source_sel <= 1'h0;
      conv_clock_output_en <= 1'h0;
      ref_trim_value <= 10'h3ff;
      status_pin <= 1'h0;
    end else begin
      config_word <= cfg_reg;
      pair_enable <= eff_word[`F_PAIR_EN]; // see [R01]
      pair_span_half <= eff_word[`F_SPAN]; // see [R02]
      internal_ref_on <= eff_word[`B_REF_ON]; // see [R03]
      ref_buffer_off <= eff_word[`B_BUF_OFF]; // see [R04]
      staggered_start_en <= eff_word[`B_STAGGER];
      auto_nap_en <= eff_word[`B_NAP]; // see [R06]
      ref_level_3v <= eff_word[`B_LEVEL]; // see [R10]
      pair_powerdown <= eff_word[`F_PD]; // see [R13]
      conv_clock_source_sel <= eff_word[`B_CLK_SEL]; // see [R14]
      conv_clock_output_en <= eff_word[`B_CLK_OUT]; // see [R15]
      ref_trim_value <= eff_word[`F_TRIM]; // see [R16]
      status_pin <= status_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial link

  serial_cfg_port u_serial (
    .sclk(sclk),
    .frame_n(frame_n),
    .sdi(sdi),
    .sdo(sdo),
    .link_rst(link_rst_reg),
    .readback_word(cfg_reg),
    .readback_tgl(cfg_tgl_reg),
    .result_word(result_word),
    .rx_word(rx_word),
    .rx_tgl(rx_tgl)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks

  wire [31:0] cfg_kept = cfg_reg & ~`CFG_UPPER_MASK;
  wire [9:0] cfg_trim = cfg_reg[`F_TRIM];
  wire [2:0] cfg_pd = cfg_reg[`F_PD];

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_first_half;
    par_take && !reset_s && par_state_reg == PAR_IDLE;
  endsequence

  sequence s_second_half;
    par_take && !reset_s && par_state_reg == PAR_HOLD;
  endsequence

  sequence s_ser_partial;
    ser_commit && !reset_s && !par_commit && !cfg_reg[`B_FULL_UPD];
  endsequence

  a_reset_default: assert property ( // see [R20]
    reset_s |=> cfg_reg == `CFG_RESET
  ) else $error("reset did not load the default word");

  a_reserved_zero: assert property ( // see [R09]
    !cfg_reg[`B_RSVD_HI] && !cfg_reg[`B_RSVD_LO]
  ) else $error("reserved bit set");

  a_par_first_half: assert property ( // see [R18]
    s_first_half |=> par_state_reg == PAR_HOLD && $stable(cfg_reg)
  ) else $error("first strobe changed the word");

  a_par_commit: assert property ( // see [R18]
    s_second_half |=> cfg_reg == $past(par_clean)
  ) else $error("second strobe did not commit");

  a_ser_partial: assert property ( // see [R12]
    s_ser_partial |=> cfg_kept == $past(cfg_kept)
  ) else $error("partial write touched lower bits");

  a_ser_full: assert property ( // see [R12]
    ser_commit && !reset_s && cfg_reg[`B_FULL_UPD]
      |=> cfg_reg == $past(rx_clean)
  ) else $error("full serial write not taken");

  a_hw_frozen: assert property ( // see [R19]
    !hw_sw_s && !reset_s |=> $stable(cfg_reg)
  ) else $error("word changed in hardware mode");

  a_hw_ignored: assert property ( // see [R17]
    !hw_sw_s |=> pair_enable == 3'h0 && !conv_clock_source_sel
      && !conv_clock_output_en && !internal_ref_on
  ) else $error("ignored setting active in hardware mode");

  a_trim_follow: assert property ( // see [R16]
    1'h1 |=> ref_trim_value == $past(cfg_trim)
  ) else $error("trim output lags the word");

  a_pd_follow: assert property ( // see [R13]
    1'h1 |=> pair_powerdown == $past(cfg_pd)
  ) else $error("power-down output lags the word");

  a_busy_level: assert property ( // see [R07]
    !irq_mode && !pol && conv_busy |=> status_pin
  ) else $error("busy not shown high");

  a_irq_level: assert property ( // see [R08]
    irq_mode && !pol && conv_irq |=> !status_pin
  ) else $error("interrupt not shown low");

endmodule

// ==== verilog/adc_cfg_defines.svh ====
// field positions, masks and reset value of the configuration word
`ifndef ADC_CFG_DEFINES_SVH
`define ADC_CFG_DEFINES_SVH

// whole-word constants
`define CFG_RESET 32'h0000_03ff
`define CFG_RSVD_MASK 32'hfff7_efff
`define CFG_HW_MASK 32'h007f_f3ff
`define CFG_UPPER_MASK 32'hff00_0000

// field positions
`define F_PAIR_EN 31:29
`define F_SPAN 28:26
`define B_REF_ON 25
`define B_BUF_OFF 24
`define B_STAGGER 23
`define B_NAP 22
`define B_IRQ_MODE 21
`define B_POL 20
`define B_RSVD_HI 19
`define B_LEVEL 18
`define B_READ_EN 17
`define B_FULL_UPD 16
`define F_PD 15:13
`define B_RSVD_LO 12
`define B_CLK_SEL 11
`define B_CLK_OUT 10
`define F_TRIM 9:0

// serial frame bit counts
`define SER_FIRST 5'h00
`define SER_LAST 5'h1f
`define SER_STEP 5'h01

`endif

// ==== verilog/adc_cfg_pkg.sv ====
// types shared by the configuration register files
package adc_cfg_pkg;

  typedef logic [31:0] cfg_word_t;

  typedef enum logic [0:0] {
    PAR_IDLE = 1'h0,
    PAR_HOLD = 1'h1
  } par_state_t;

endpackage

// ==== verilog/cfg_sync.sv ====
// two-flop synchroniser for pins entering the system clock domain
`timescale 1ns/100ps
module cfg_sync #(
  parameter int WIDTH = 1
) (
  // clock
  input wire logic clk,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // no reset: the pair settles within two edges of any reset pulse
  always_ff @(posedge clk) begin
    meta_reg <= d;
    q <= meta_reg;
  end

endmodule

// ==== verilog/serial_cfg_port.sv ====
// serial link end: shifts words in and out on the link clock
`timescale 1ns/100ps
`include "adc_cfg_defines.svh"
module serial_cfg_port
  import adc_cfg_pkg::*;
(
  // link
  input wire logic sclk,
  input wire logic frame_n,
  input wire logic sdi,
  output logic sdo,
  // system side
  input wire logic link_rst,
  input wire logic [31:0] readback_word,
  input wire logic readback_tgl,
  input wire logic [31:0] result_word,
  output cfg_word_t rx_word,
  output logic rx_tgl
);

  logic [1:0] tgl_sync_reg;
  logic seen_reg;
  cfg_word_t copy_reg;
  logic [4:0] bit_cnt_reg;
  logic [30:0] shift_in_reg;
  logic [31:0] shift_out_reg;

  wire copy_due = tgl_sync_reg[1] ^ seen_reg;
  wire first_bit = (bit_cnt_reg == `SER_FIRST);
  wire last_bit = (bit_cnt_reg == `SER_LAST);
  // readback replaces results while the copied word asks for it
  wire [31:0] tx_word = copy_reg[`B_READ_EN] ? copy_reg : result_word; // see [R11]

  // the word is only copied once its toggle has settled here
  always_ff @(negedge sclk or posedge link_rst) begin
    if (link_rst) begin
      tgl_sync_reg <= 2'h0;
      seen_reg <= 1'h0;
      copy_reg <= `CFG_RESET;
    end else begin
      tgl_sync_reg <= {tgl_sync_reg[0], readback_tgl};
      if (copy_due) begin
        seen_reg <= tgl_sync_reg[1];
        copy_reg <= readback_word;
      end
    end
  end

  // frame end clears the count, so a stopped clock leaves no stale state
  always_ff @(negedge sclk or posedge frame_n) begin
    if (frame_n) begin
      bit_cnt_reg <= `SER_FIRST;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + `SER_STEP;
    end
  end

  always_ff @(negedge sclk or posedge link_rst) begin
    if (link_rst) begin
      sdo <= 1'h0;
      shift_in_reg <= 31'h0;
      shift_out_reg <= 32'h0;
      rx_word <= `CFG_RESET;
      rx_tgl <= 1'h0;
    end else if (!frame_n) begin
      shift_in_reg <= {shift_in_reg[29:0], sdi};
      if (first_bit) begin
        sdo <= tx_word[31];
        shift_out_reg <= {tx_word[30:0], 1'h0};
      end else begin
        sdo <= shift_out_reg[31];
        shift_out_reg <= {shift_out_reg[30:0], 1'h0};
      end
      if (last_bit) begin
        rx_word <= {shift_in_reg, sdi}; // see [R18]
        rx_tgl <= ~rx_tgl;
      end
    end
  end

endmodule

// ==== verilog/unused_placeholder.sv ====
// empty on purpose
`timescale 1ns/100ps

// ==== test/host_model.sv ====
// host model driving the parallel and serial configuration ports
`timescale 1ns/100ps
module host_model (
  // system
  input wire logic clk_sys,
  // parallel port
  output logic wr_n,
  output logic cs_n,
  output logic [15:0] par_data,
  // serial link
  output logic sclk,
  output logic frame_n,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    wr_n = 1'h1;
    cs_n = 1'h1;
    par_data = 16'h0000;
    sclk = 1'h1;
    frame_n = 1'h1;
    sdi = 1'h0;
  end
  //////////////////////////////////////////////////////////////////////////
  // a careful host keeps the word legal unless told to misbehave
  function automatic logic [31:0] legal(input logic [31:0] w);
    logic [31:0] v;
    v = w & 32'hfff7_efff;
    v[23] = w[23] & w[11];
    v[31:29] = w[31:29] & ~w[15:13];
    return v;
  endfunction
  // data held well past the rise so the synchronised copy still sees it
  task automatic half(input logic [15:0] d);
    @(negedge clk_sys);
    cs_n = 1'h0;
    par_data = d;
    wr_n = 1'h0;
    repeat (4) @(negedge clk_sys);
    wr_n = 1'h1;
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic par_write(input logic [31:0] w, input logic raw);
    logic [31:0] v;
    v = raw ? w : legal(w);
    half(v[31:16]);
    half(v[15:0]);
    cs_n = 1'h1;
    par_data = ~par_data;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // link clock only runs inside a frame and rests high between frames
  task automatic frame(input logic [31:0] w, input int bits,
                       output logic [31:0] rd);
    rd = 32'h0;
    #3;
    frame_n = 1'h0;
    for (int i = 31; i > 31 - bits; i--) begin
      sclk = 1'h1;
      sdi = w[i];
      #7.5;
      sclk = 1'h0;
      #7.5;
      rd = {rd[30:0], sdo};
    end
    sclk = 1'h1;
    #7.5;
    frame_n = 1'h1;
    sdi = ~sdi;
  endtask
endmodule

// ==== test/adc_control_register_test.sv ====
// self-checking bench for the configuration word block
`timescale 1ns/100ps
`include "adc_cfg_defines.svh"
module adc_control_register_test import adc_cfg_pkg::*;;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic reset_pin = 1'h0;
  logic hw_sw_pin = 1'h1;
  logic par_mode_pin = 1'h1;
  logic conv_busy = 1'h0;
  logic conv_irq = 1'h0;
  logic [31:0] result_word = 32'h3c5a_96e1;
  wire logic wr_n, cs_n, sclk, frame_n, sdi, sdo;
  wire logic [15:0] par_data;
  logic status_pin;
  cfg_word_t config_word;
  logic [2:0] pair_enable, pair_span_half, pair_powerdown;
  logic internal_ref_on, ref_buffer_off, staggered_start_en, auto_nap_en;
  logic ref_level_3v, conv_clock_source_sel, conv_clock_output_en;
  logic [9:0] ref_trim_value;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [31:0] rd;
  typedef struct packed {
    logic [31:0] word;
    logic [31:0] exp;
    logic busy;
    logic irq;
    logic stat;
  } row_t;
  row_t rows [4] = '{
    '{32'he265_065a, 32'he265_065a, 1'h0, 1'h1, 1'h0},
    '{32'h1d9c_e9a5, 32'h1d94_e9a5, 1'h1, 1'h0, 1'h0},
    '{32'h0000_0000, 32'h0000_0000, 1'h1, 1'h1, 1'h1},
    '{32'h8030_0000, 32'h8030_0000, 1'h0, 1'h0, 1'h0}
  };
  always #20 clk_sys = ~clk_sys;
  adc_control_register adc_control_register_inst (.clk_sys, .rst,
    .reset_pin, .hw_sw_pin, .par_mode_pin, .wr_n, .cs_n, .par_data, .sclk,
    .frame_n, .sdi, .sdo, .result_word, .conv_busy, .conv_irq, .status_pin,
    .config_word, .pair_enable, .pair_span_half, .internal_ref_on,
    .ref_buffer_off, .staggered_start_en, .auto_nap_en, .ref_level_3v,
    .pair_powerdown, .conv_clock_source_sel, .conv_clock_output_en,
    .ref_trim_value);
  host_model host_model_inst (.clk_sys, .wr_n, .cs_n, .par_data, .sclk,
    .frame_n, .sdi, .sdo);
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // views gated by hardware mode read zero there; the rest always follow
  task automatic views(input logic [31:0] w, input logic hw);
    logic [31:0] g;
    logic [31:0] a;
    g = {21'h0, pair_enable, pair_span_half, internal_ref_on, ref_buffer_off,
         staggered_start_en, conv_clock_source_sel, conv_clock_output_en};
    a = {17'h0, auto_nap_en, ref_level_3v, pair_powerdown, ref_trim_value};
    check("config", config_word, w);
    check("gated", g, {21'h0, {w[31:23], w[11:10]} & {11{~hw}}});
    check("always", a, {17'h0, w[22], w[18], w[15:13], w[9:0]});
  endtask
  task automatic wrap_up();
    if (failures == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      failures++;
      wrap_up();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge clk_sys);
    rst = 1'h0;
    repeat (4) @(negedge clk_sys);
    views(`CFG_RESET, 1'h0);
    foreach (rows[i]) begin
      conv_busy = rows[i].busy;
      conv_irq = rows[i].irq;
      host_model_inst.par_write(rows[i].word, 1'h0);
      repeat (6) @(negedge clk_sys);
      views(rows[i].exp, 1'h0);
      check("status", {31'h0, status_pin}, {31'h0, rows[i].stat});
    end
    // every bit set, reserved ones included
    host_model_inst.par_write(32'hffff_ffff, 1'h1);
    repeat (6) @(negedge clk_sys);
    views(32'hfff7_efff, 1'h0);
    hw_sw_pin = 1'h0;
    repeat (6) @(negedge clk_sys);
    views(32'hfff7_efff, 1'h1);
    host_model_inst.par_write(32'h0000_0000, 1'h0);
    repeat (6) @(negedge clk_sys);
    views(32'hfff7_efff, 1'h1);
    hw_sw_pin = 1'h1;
    host_model_inst.par_write(32'h0003_0000, 1'h0);
    par_mode_pin = 1'h0;
    repeat (6) @(negedge clk_sys);
    host_model_inst.frame(32'h2a13_c0f0, 32, rd);
    // link copy still holds the reset word, so results go out
    check("results", rd, result_word);
    repeat (10) @(negedge clk_sys);
    check("serial full", config_word, 32'h2a13_c0f0);
    host_model_inst.frame(32'h0000_0000, 4, rd);
    repeat (10) @(negedge clk_sys);
    check("short frame", config_word, 32'h2a13_c0f0);
    host_model_inst.frame(32'h4400_0000, 32, rd);
    repeat (10) @(negedge clk_sys);
    check("readback", rd, 32'h2a13_c0f0);
    check("serial z", config_word, 32'h4400_0000);
    // lower bits legal but ignored: only the upper byte may land
    host_model_inst.frame(32'h8177_0fff, 32, rd);
    host_model_inst.par_write(32'h0000_0000, 1'h0);
    check("upper only", config_word, 32'h8100_0000);
    reset_pin = 1'h1;
    repeat (3) @(negedge clk_sys);
    reset_pin = 1'h0;
    repeat (6) @(negedge clk_sys);
    views(`CFG_RESET, 1'h0);
    par_mode_pin = 1'h1;
    host_model_inst.par_write(rows[0].word, 1'h0);
    rst = 1'h1;
    repeat (3) @(negedge clk_sys);
    rst = 1'h0;
    repeat (4) @(negedge clk_sys);
    views(`CFG_RESET, 1'h0);
    wrap_up();
  end
endmodule
